// [design/isc_device.sv]
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Function
// - Eight request sources feed the flags
// - Per-source enable bit gates each request
// - Hardware sets flags; software write clears
// - Edge select: rising, falling or both
// - Global enable set/cleared by instructions
// - Flags set even when source disabled
// - Software keeps stack pointer bit0 zero
// - Entry pushes PC, sp+2, clears global, vectors
// - Return pops PC, sp-2, sets global
// - Software reserves two stack bytes per level
// - Flag register readable during service
// - Modes: run, light sleep, deep sleep
// - Light sleep stops only system clock
// - Low-speed oscillator stays on in light
// - Sysclk timers halt in light sleep
// - Light wake on enabled input pin toggle
// - Light wake on non-sysclk timer target
// - Comparator wake needs both enable bits
// - Deep sleep stops oscillators, program memory
// - Deep sleep keeps memory and registers
// - Deep wake only by enabled pin toggle
// - Wake resumes after sleep instruction
// - Wake delay 3000 or 45 slow periods
module isc_device
    import isc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    isc_if.device link,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [7:0] pin_s1_reg, pin_s2_reg, pin_prev_reg;
    logic [7:0] src_prev_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_reg <= ISC_RST_BYTE;
            pin_s2_reg <= ISC_RST_BYTE;
            pin_prev_reg <= ISC_RST_BYTE;
            src_prev_reg <= ISC_RST_BYTE;
        end else begin
            pin_s1_reg <= link.pin_level;
            pin_s2_reg <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg;
            src_prev_reg <= link.src_level;
        end
    end

    // ****************************************
    // Request flags
    // ****************************************
    logic [7:0] flags_reg, enable_reg;
    logic [15:0] edge_reg;
    logic [7:0] rise, fall, hit;
    logic gie_reg;
    assign rise = link.src_level & ~src_prev_reg;
    assign fall = ~link.src_level & src_prev_reg;
    genvar gi;
    generate
        for (gi = 0; gi < ISC_NSRC; gi++) begin : g_edge
            wire [1:0] sel = edge_reg[2*gi +: 2];
            assign hit[gi] = (sel == ISC_EDGE_RISE) ? rise[gi] :
                             (sel == ISC_EDGE_FALL) ? fall[gi] : (rise[gi] | fall[gi]);
        end
    endgenerate

    wire wr_flags = reg_we && reg_addr == ISC_REG_FLAGS;
    // Write one to clear; a new edge in the same cycle wins
    wire [7:0] flags_next = (flags_reg & ~(wr_flags ? reg_wdata : ISC_RST_BYTE)) | hit;

    // ****************************************
    // Modes and sequencer
    // ****************************************
    isc_mode_e mode_reg, mode_next;
    isc_seq_e seq_reg, seq_next;
    logic [7:0] sp_reg;
    logic [15:0] pc_save_reg;
    logic [7:0] pc_lo_reg;
    logic [2:0] cfg_reg;
    logic [11:0] wake_cnt_reg;

    wire irq_pending = |(flags_reg & enable_reg) && gie_reg;
    wire run = mode_reg == ISC_RUN;
    wire start_irq = run && seq_reg == ISC_IDLE && link.instr_boundary && irq_pending;
    wire start_reti = run && seq_reg == ISC_IDLE && link.op_reti && !start_irq;
    wire pin_toggle_light = |((pin_s2_reg ^ pin_prev_reg) & link.pin_direction_bit & link.pin_dier);
    wire pin_toggle_deep = |((pin_s2_reg ^ pin_prev_reg) & link.pin_dier);
    wire timer_wake = link.timer_target_hit && !link.timer_on_sysclk;
    wire cmp_wake = link.cmp_event && cfg_reg[ISC_CFG_CMP_EN] && cfg_reg[ISC_CFG_CMP_WAKE];
    wire light_wake = pin_toggle_light || timer_wake || cmp_wake;
    wire [11:0] wake_len = cfg_reg[ISC_CFG_FAST] ? ISC_WAKE_FAST : ISC_WAKE_NORMAL;

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            ISC_RUN: begin
                if (seq_reg == ISC_IDLE && link.op_stopsys) begin
                    mode_next = ISC_DEEP;
                end else if (seq_reg == ISC_IDLE && link.op_stopexe) begin
                    mode_next = ISC_LIGHT;
                end
            end
            ISC_LIGHT: if (light_wake) mode_next = ISC_WAKING;
            ISC_DEEP: if (pin_toggle_deep) mode_next = ISC_WAKING;
            ISC_WAKING: if (wake_cnt_reg == 12'h000) mode_next = ISC_RUN;
            default: mode_next = ISC_RUN;
        endcase
    end

    always_comb begin
        seq_next = seq_reg;
        case (seq_reg)
            ISC_IDLE: begin
                if (start_irq) seq_next = ISC_PUSH_LO;
                else if (start_reti) seq_next = ISC_POP_LO;
            end
            ISC_PUSH_LO: seq_next = ISC_PUSH_HI;
            ISC_PUSH_HI: seq_next = ISC_IDLE;
            ISC_POP_LO: seq_next = ISC_POP_HI;
            ISC_POP_HI: seq_next = ISC_IDLE;
            default: seq_next = ISC_IDLE;
        endcase
    end

    wire wr_sp = reg_we && reg_addr == ISC_REG_SP && seq_reg == ISC_IDLE;
    // Pop reads the word just below the current pointer
    wire [7:0] sp_minus = sp_reg - ISC_SP_STEP;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_reg <= ISC_RST_BYTE;
            enable_reg <= ISC_RST_BYTE;
            edge_reg <= ISC_RST_WORD;
            gie_reg <= 1'b0;
            mode_reg <= ISC_RUN;
            seq_reg <= ISC_IDLE;
            sp_reg <= ISC_RST_BYTE;
            pc_save_reg <= ISC_RST_WORD;
            pc_lo_reg <= ISC_RST_BYTE;
            cfg_reg <= 3'h0;
            wake_cnt_reg <= 12'h000;
        end else begin
            flags_reg <= flags_next;
            mode_reg <= mode_next;
            seq_reg <= seq_next;
            if (reg_we && reg_addr == ISC_REG_ENABLE) enable_reg <= reg_wdata;
            if (reg_we && reg_addr == ISC_REG_EDGE_LO) edge_reg[7:0] <= reg_wdata;
            if (reg_we && reg_addr == ISC_REG_EDGE_HI) edge_reg[15:8] <= reg_wdata;
            if (reg_we && reg_addr == ISC_REG_WAKE_CFG) cfg_reg <= reg_wdata[2:0];
            if (start_irq) begin
                pc_save_reg <= link.pc_now;
                gie_reg <= 1'b0;
            end else if (seq_reg == ISC_POP_HI) begin
                gie_reg <= 1'b1;
            end else if (run && link.op_engint) begin
                gie_reg <= 1'b1;
            end else if (run && link.op_disgint) begin
                gie_reg <= 1'b0;
            end
            if (wr_sp) sp_reg <= reg_wdata;
            else if (seq_reg == ISC_PUSH_HI) sp_reg <= sp_reg + ISC_SP_STEP;
            else if (seq_reg == ISC_POP_HI) sp_reg <= sp_minus;
            if (seq_reg == ISC_POP_LO) pc_lo_reg <= link.mem_rdata;
            if (mode_next == ISC_WAKING && mode_reg != ISC_WAKING) wake_cnt_reg <= wake_len;
            else if (mode_reg == ISC_WAKING && link.low_speed_tick && wake_cnt_reg != 12'h000)
                wake_cnt_reg <= wake_cnt_reg - 12'h001;
        end
    end

    // ****************************************
    // Core and memory outputs
    // ****************************************
    assign link.take_irq = start_irq;
    assign link.seq_busy = seq_reg != ISC_IDLE;
    assign link.mem_we = seq_reg == ISC_PUSH_LO || seq_reg == ISC_PUSH_HI;
    assign link.mem_re = seq_reg == ISC_POP_LO || seq_reg == ISC_POP_HI;
    assign link.mem_addr = (seq_reg == ISC_PUSH_LO) ? sp_reg :
                           (seq_reg == ISC_PUSH_HI) ? sp_reg + 8'h01 :
                           (seq_reg == ISC_POP_LO) ? sp_minus :
                           (seq_reg == ISC_POP_HI) ? sp_minus + 8'h01 : ISC_RST_BYTE;
    assign link.mem_wdata = (seq_reg == ISC_PUSH_HI) ? pc_save_reg[15:8] : pc_save_reg[7:0];
    assign link.vector_load = seq_reg == ISC_PUSH_HI;
    assign link.pc_load_en = seq_reg == ISC_PUSH_HI || seq_reg == ISC_POP_HI;
    assign link.pc_load = (seq_reg == ISC_PUSH_HI) ? ISC_VECTOR : {link.mem_rdata, pc_lo_reg};
    // Core halts in every mode but run and while the sequencer is busy; state registers hold
    assign link.core_halt = !run || seq_reg != ISC_IDLE;
    assign link.sysclk_enable = run;
    assign link.high_speed_osc_en = mode_reg != ISC_DEEP;
    assign link.external_osc_en = mode_reg != ISC_DEEP;
    assign link.low_speed_osc_en = mode_reg != ISC_DEEP;
    assign link.prog_mem_power = mode_reg != ISC_DEEP;
    assign link.timers_run_sysclk = run;

    // ****************************************
    // Register read port
    // ****************************************
    wire [7:0] status = {5'h00, mode_reg, gie_reg};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= ISC_RST_BYTE;
        end else if (reg_re) begin
            case (reg_addr)
                ISC_REG_FLAGS: reg_rdata <= flags_reg;
                ISC_REG_ENABLE: reg_rdata <= enable_reg;
                ISC_REG_EDGE_LO: reg_rdata <= edge_reg[7:0];
                ISC_REG_EDGE_HI: reg_rdata <= edge_reg[15:8];
                ISC_REG_SP: reg_rdata <= sp_reg;
                ISC_REG_STATUS: reg_rdata <= status;
                ISC_REG_WAKE_CFG: reg_rdata <= {5'h00, cfg_reg};
                default: reg_rdata <= ISC_RST_BYTE;
            endcase
        end else begin
            reg_rdata <= ISC_RST_BYTE;
        end
    end
endmodule : isc_device

// [design/isc_pkg.sv]
package isc_pkg;
    localparam int ISC_NSRC = 8;
    localparam logic [15:0] ISC_VECTOR = 16'h0010;
    localparam logic [7:0] ISC_SP_STEP = 8'h02;
    localparam logic [7:0] ISC_RST_BYTE = 8'h00;
    localparam logic [15:0] ISC_RST_WORD = 16'h0000;
    // Source positions
    localparam int ISC_SRC_EXT0 = 0;
    localparam int ISC_SRC_EXT1 = 1;
    localparam int ISC_SRC_CONV = 2;
    localparam int ISC_SRC_WIDE_TIMER = 3;
    localparam int ISC_SRC_CMP_PWM1 = 4;
    localparam int ISC_SRC_PWM0 = 5;
    localparam int ISC_SRC_TIMER2 = 6;
    localparam int ISC_SRC_TIMER3 = 7;
    // Edge select encodings, two bits per source
    localparam logic [1:0] ISC_EDGE_BOTH = 2'h0;
    localparam logic [1:0] ISC_EDGE_RISE = 2'h1;
    localparam logic [1:0] ISC_EDGE_FALL = 2'h2;
    // Wake delay in low-speed oscillator periods
    localparam logic [11:0] ISC_WAKE_NORMAL = 12'hbb8;
    localparam logic [11:0] ISC_WAKE_FAST = 12'h02d;
    // Controller register offsets
    localparam logic [3:0] ISC_REG_FLAGS = 4'h0;
    localparam logic [3:0] ISC_REG_ENABLE = 4'h1;
    localparam logic [3:0] ISC_REG_EDGE_LO = 4'h2;
    localparam logic [3:0] ISC_REG_EDGE_HI = 4'h3;
    localparam logic [3:0] ISC_REG_SP = 4'h4;
    localparam logic [3:0] ISC_REG_STATUS = 4'h5;
    localparam logic [3:0] ISC_REG_WAKE_CFG = 4'h6;
    localparam int ISC_STAT_GIE = 0;
    localparam int ISC_STAT_MODE_LO = 1;
    localparam int ISC_CFG_FAST = 0;
    localparam int ISC_CFG_CMP_EN = 1;
    localparam int ISC_CFG_CMP_WAKE = 2;
    typedef enum logic [1:0] {
        ISC_RUN = 2'b00,
        ISC_LIGHT = 2'b01,
        ISC_WAKING = 2'b11,
        ISC_DEEP = 2'b10
    } isc_mode_e;
    typedef enum logic [2:0] {
        ISC_IDLE = 3'b000,
        ISC_PUSH_LO = 3'b001,
        ISC_PUSH_HI = 3'b011,
        ISC_POP_LO = 3'b010,
        ISC_POP_HI = 3'b110
    } isc_seq_e;
endpackage : isc_pkg

// [design/isc_if.sv]
`timescale 1ns/1ps
interface isc_if (
    input wire logic clk,
    input wire logic nrst
);
    import isc_pkg::*;
    // Core instruction strobes and stack memory port
    logic instr_boundary;
    logic op_engint;
    logic op_disgint;
    logic op_reti;
    logic op_stopexe;
    logic op_stopsys;
    logic [15:0] pc_now;
    logic take_irq;
    logic vector_load;
    logic [15:0] pc_load;
    logic pc_load_en;
    logic core_halt;
    logic mem_we;
    logic mem_re;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic seq_busy;
    // Peripheral and pin side
    logic [7:0] src_level;
    logic [7:0] pin_level;
    logic [7:0] pin_direction_bit;
    logic [7:0] pin_dier;
    logic timer_target_hit;
    logic timer_on_sysclk;
    logic cmp_event;
    logic low_speed_tick;
    logic sysclk_enable;
    logic high_speed_osc_en;
    logic low_speed_osc_en;
    logic external_osc_en;
    logic prog_mem_power;
    logic timers_run_sysclk;
    modport device (
        input instr_boundary, op_engint, op_disgint, op_reti, op_stopexe, op_stopsys, pc_now, mem_rdata,
        input src_level, pin_level, pin_direction_bit, pin_dier, timer_target_hit, timer_on_sysclk,
        input cmp_event, low_speed_tick,
        output take_irq, vector_load, pc_load, pc_load_en, core_halt, mem_we, mem_re, mem_addr, mem_wdata,
        output seq_busy, sysclk_enable, high_speed_osc_en, low_speed_osc_en, external_osc_en,
        output prog_mem_power, timers_run_sysclk
    );
    modport core (
        output instr_boundary, op_engint, op_disgint, op_reti, op_stopexe, op_stopsys, pc_now, mem_rdata,
        output src_level, pin_level, pin_direction_bit, pin_dier, timer_target_hit, timer_on_sysclk,
        output cmp_event, low_speed_tick,
        input take_irq, vector_load, pc_load, pc_load_en, core_halt, mem_we, mem_re, mem_addr, mem_wdata,
        input seq_busy, sysclk_enable, high_speed_osc_en, low_speed_osc_en, external_osc_en,
        input prog_mem_power, timers_run_sysclk
    );
endinterface : isc_if

// [design/isc_core_end.sv]
`timescale 1ns/1ps
// Far end: registers core strobes and peripheral signals onto the link; pin levels and memory read data pass through unregistered.
module isc_core_end
    import isc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    isc_if.core link,
    input wire logic u_boundary,
    input wire logic u_engint,
    input wire logic u_disgint,
    input wire logic u_reti,
    input wire logic u_stopexe,
    input wire logic u_stopsys,
    input wire logic [15:0] u_pc,
    input wire logic [7:0] u_mem_rdata,
    input wire logic [7:0] u_src_level,
    input wire logic [7:0] u_pin_level,
    input wire logic [7:0] u_pin_direction_bit,
    input wire logic [7:0] u_pin_dier,
    input wire logic u_timer_hit,
    input wire logic u_timer_on_sysclk,
    input wire logic u_cmp_event,
    input wire logic u_low_speed_tick,
    output logic u_take_irq,
    output logic u_pc_load_en,
    output logic [15:0] u_pc_load,
    output logic u_halt,
    output logic u_mem_we,
    output logic u_mem_re,
    output logic [7:0] u_mem_addr,
    output logic [7:0] u_mem_wdata
);
    // Instruction strobes suppressed while the core is halted: outside run mode or while the sequencer owns the core
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            link.instr_boundary <= 1'b0;
            link.op_engint <= 1'b0;
            link.op_disgint <= 1'b0;
            link.op_reti <= 1'b0;
            link.op_stopexe <= 1'b0;
            link.op_stopsys <= 1'b0;
            link.pc_now <= ISC_RST_WORD;
            link.src_level <= ISC_RST_BYTE;
            link.pin_direction_bit <= ISC_RST_BYTE;
            link.pin_dier <= ISC_RST_BYTE;
            link.timer_target_hit <= 1'b0;
            link.timer_on_sysclk <= 1'b0;
            link.cmp_event <= 1'b0;
            link.low_speed_tick <= 1'b0;
        end else begin
            link.instr_boundary <= u_boundary && !link.core_halt;
            link.op_engint <= u_engint && !link.core_halt;
            link.op_disgint <= u_disgint && !link.core_halt;
            link.op_reti <= u_reti && !link.core_halt;
            link.op_stopexe <= u_stopexe && !link.core_halt;
            link.op_stopsys <= u_stopsys && !link.core_halt;
            link.pc_now <= u_pc;
            link.src_level <= u_src_level;
            link.pin_direction_bit <= u_pin_direction_bit;
            link.pin_dier <= u_pin_dier;
            link.timer_target_hit <= u_timer_hit;
            link.timer_on_sysclk <= u_timer_on_sysclk;
            link.cmp_event <= u_cmp_event;
            link.low_speed_tick <= u_low_speed_tick;
        end
    end
    assign link.pin_level = u_pin_level;
    assign link.mem_rdata = u_mem_rdata;
    assign u_take_irq = link.take_irq;
    assign u_pc_load_en = link.pc_load_en;
    assign u_pc_load = link.pc_load;
    assign u_halt = link.core_halt;
    assign u_mem_we = link.mem_we;
    assign u_mem_re = link.mem_re;
    assign u_mem_addr = link.mem_addr;
    assign u_mem_wdata = link.mem_wdata;
endmodule : isc_core_end

// [verif/isc_monitor.sv]
`timescale 1ns/1ps
module isc_monitor
    import isc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic instr_boundary,
    input wire logic op_reti,
    input wire logic op_stopexe,
    input wire logic op_stopsys,
    input wire logic [15:0] pc_now,
    input wire logic [7:0] mem_rdata,
    input wire logic take_irq,
    input wire logic vector_load,
    input wire logic [15:0] pc_load,
    input wire logic pc_load_en,
    input wire logic core_halt,
    input wire logic mem_we,
    input wire logic mem_re,
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic seq_busy,
    input wire logic sysclk_enable,
    input wire logic high_speed_osc_en,
    input wire logic low_speed_osc_en,
    input wire logic external_osc_en,
    input wire logic prog_mem_power,
    input wire logic timers_run_sysclk
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // ****************************************
    // Entry and return sequences
    // ****************************************
    property p_take_at_boundary;
        take_irq |-> instr_boundary && !seq_busy;
    endproperty
    a_take_at_boundary: assert property (p_take_at_boundary) else $error("take outside boundary");
    property p_push_pc;
        take_irq |=> mem_we && !mem_re && mem_wdata == $past(pc_now[7:0])
            ##1 mem_we && mem_addr == $past(mem_addr) + 8'h01 && mem_wdata == $past(pc_now[15:8], 2);
    endproperty
    a_push_pc: assert property (p_push_pc) else $error("pc push wrong");
    property p_vector;
        take_irq |-> ##2 pc_load_en && vector_load && pc_load == ISC_VECTOR;
    endproperty
    a_vector: assert property (p_vector) else $error("vector fetch wrong");
    property p_no_retake;
        take_irq |=> (seq_busy && !take_irq) [*2];
    endproperty
    a_no_retake: assert property (p_no_retake) else $error("take during entry");
    property p_pop;
        op_reti && !take_irq && !seq_busy && !core_halt |=> mem_re && !mem_we
            ##1 mem_re && mem_addr == $past(mem_addr) + 8'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("pc pop wrong");
    property p_restore;
        op_reti && !take_irq && !seq_busy && !core_halt |-> ##2 pc_load_en && pc_load == {mem_rdata, $past(mem_rdata)};
    endproperty
    a_restore: assert property (p_restore) else $error("pc restore wrong");
    // ****************************************
    // Sleep modes
    // ****************************************
    property p_light;
        op_stopexe && !op_stopsys && !seq_busy && !core_halt |=> core_halt && !sysclk_enable
            && high_speed_osc_en && low_speed_osc_en && external_osc_en;
    endproperty
    a_light: assert property (p_light) else $error("light sleep clocks wrong");
    property p_deep;
        op_stopsys && !seq_busy && !core_halt |=> core_halt && !high_speed_osc_en && !low_speed_osc_en
            && !external_osc_en && !prog_mem_power;
    endproperty
    a_deep: assert property (p_deep) else $error("deep sleep clocks wrong");
    property p_timer_halt;
        !sysclk_enable |-> core_halt && !timers_run_sysclk;
    endproperty
    a_timer_halt: assert property (p_timer_halt) else $error("sysclk timers run in sleep");
    property p_halt_no_take;
        core_halt && !seq_busy |-> !take_irq;
    endproperty
    a_halt_no_take: assert property (p_halt_no_take) else $error("take while asleep");
endmodule : isc_monitor

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top
    import isc_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] strb = 8'h00;
    logic [7:0] src = 8'h00;
    logic [7:0] pin = 8'h00;
    logic [7:0] dir = 8'h00;
    logic on_sys = 1'b1;
    logic take, pc_en, halt, we;
    logic [15:0] pc_ld;
    logic [7:0] maddr, mwdata;
    logic [7:0] mem [0:255];
    logic [15:0] pc_seen = 16'h0000;
    logic [15:0] takes = 16'h0000;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    isc_if ifc (.clk(clk), .nrst(nrst));
    isc_device i_isc_device (.clk(clk), .nrst(nrst), .link(ifc.device), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
    // Strobe bits: 0-5 core ops, 6 timer hit, 7 comparator event
    isc_core_end i_isc_core_end (.clk(clk), .nrst(nrst), .link(ifc.core), .u_boundary(strb[0]),
        .u_engint(strb[1]), .u_disgint(strb[2]), .u_reti(strb[3]), .u_stopexe(strb[4]), .u_stopsys(strb[5]),
        .u_pc(16'h1234), .u_mem_rdata(mem[maddr]), .u_src_level(src), .u_pin_level(pin),
        .u_pin_direction_bit(dir), .u_pin_dier(8'h01), .u_timer_hit(strb[6]), .u_timer_on_sysclk(on_sys),
        .u_cmp_event(strb[7]), .u_low_speed_tick(1'b1), .u_take_irq(take), .u_pc_load_en(pc_en),
        .u_pc_load(pc_ld), .u_halt(halt), .u_mem_we(we), .u_mem_re(), .u_mem_addr(maddr), .u_mem_wdata(mwdata));
    isc_monitor i_isc_monitor (.clk(clk), .nrst(nrst), .instr_boundary(ifc.instr_boundary),
        .op_reti(ifc.op_reti), .op_stopexe(ifc.op_stopexe), .op_stopsys(ifc.op_stopsys), .pc_now(ifc.pc_now),
        .mem_rdata(ifc.mem_rdata), .take_irq(ifc.take_irq), .vector_load(ifc.vector_load),
        .pc_load(ifc.pc_load), .pc_load_en(ifc.pc_load_en), .core_halt(ifc.core_halt), .mem_we(ifc.mem_we),
        .mem_re(ifc.mem_re), .mem_addr(ifc.mem_addr), .mem_wdata(ifc.mem_wdata), .seq_busy(ifc.seq_busy),
        .sysclk_enable(ifc.sysclk_enable), .high_speed_osc_en(ifc.high_speed_osc_en),
        .low_speed_osc_en(ifc.low_speed_osc_en), .external_osc_en(ifc.external_osc_en),
        .prog_mem_power(ifc.prog_mem_power), .timers_run_sysclk(ifc.timers_run_sysclk));
    // ****************************************
    // Helpers
    // ****************************************
    task test_done();
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, e});
    endtask : rd
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask : wr
    task pulse(input int k);
        @(posedge clk);
        strb <= 8'h01 << k;
        @(posedge clk);
        strb <= 8'h00;
    endtask : pulse
    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task set_src(input logic [7:0] v);
        @(posedge clk);
        src <= v;
        idle(4);
    endtask : set_src
    // Wake time measured from the event to the release of the core halt
    task wake_chk(input int w);
        int n;
        n = 0;
        while (halt !== 1'b0 && n < 4000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({15'h0000, (n >= w) && (n <= w + 10)}, 16'h0001);
    endtask : wake_chk
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (we === 1'b1) mem[maddr] <= mwdata;
        if (pc_en === 1'b1) pc_seen <= pc_ld;
        if (take === 1'b1) takes <= takes + 16'h0001;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(ISC_REG_STATUS, 8'h00);
        rd(4'hf, 8'h00);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            src <= src | (8'h01 << i);
        end
        idle(4);
        rd(ISC_REG_FLAGS, 8'hff);
        wr(ISC_REG_FLAGS, 8'hff);
        rd(ISC_REG_FLAGS, 8'h00);
        set_src(8'h00);
        rd(ISC_REG_FLAGS, 8'hff);
        wr(ISC_REG_FLAGS, 8'hff);
        wr(ISC_REG_EDGE_LO, 8'h99);
        wr(ISC_REG_EDGE_HI, 8'h03);
        set_src(8'h1f);
        rd(ISC_REG_FLAGS, 8'h15);
        set_src(8'h00);
        rd(ISC_REG_FLAGS, 8'h1f);
        wr(ISC_REG_FLAGS, 8'hff);
        wr(ISC_REG_SP, 8'h20);
        pulse(1);
        set_src(8'h01);
        rd(ISC_REG_STATUS, 8'h01);
        pulse(0);
        idle(4);
        chk(takes, 16'h0000);
        wr(ISC_REG_ENABLE, 8'h01);
        pulse(2);
        pulse(0);
        idle(4);
        chk(takes, 16'h0000);
        pulse(1);
        pulse(0);
        idle(6);
        chk(takes, 16'h0001);
        chk({mem[8'h21], mem[8'h20]}, 16'h1234);
        chk(pc_seen, ISC_VECTOR);
        rd(ISC_REG_SP, 8'h22);
        rd(ISC_REG_STATUS, 8'h00);
        rd(ISC_REG_FLAGS, 8'h01);
        wr(ISC_REG_FLAGS, 8'h01);
        pulse(3);
        idle(6);
        chk(pc_seen, 16'h1234);
        rd(ISC_REG_SP, 8'h20);
        rd(ISC_REG_STATUS, 8'h01);
        // Light sleep: wrong pin mode, sysclk timer and gated comparator must not wake
        wr(ISC_REG_WAKE_CFG, 8'h01);
        pulse(4);
        rd(ISC_REG_STATUS, 8'h03);
        chk({14'h0000, ifc.sysclk_enable, ifc.low_speed_osc_en}, 16'h0001);
        @(posedge clk);
        pin <= 8'h01;
        idle(6);
        pulse(6);
        idle(4);
        pulse(7);
        idle(4);
        rd(ISC_REG_STATUS, 8'h03);
        wr(ISC_REG_WAKE_CFG, 8'h07);
        pulse(7);
        wake_chk(45);
        rd(ISC_REG_STATUS, 8'h01);
        pulse(4);
        on_sys <= 1'b0;
        pulse(6);
        wake_chk(45);
        // Input-mode pin toggle wakes light sleep
        pulse(4);
        dir <= 8'h01;
        idle(2);
        pin <= 8'h00;
        wake_chk(45);
        // Deep sleep with normal wake time
        wr(ISC_REG_WAKE_CFG, 8'h00);
        dir <= 8'h00;
        pulse(5);
        rd(ISC_REG_STATUS, 8'h05);
        chk({14'h0000, ifc.high_speed_osc_en, ifc.prog_mem_power}, 16'h0000);
        rd(ISC_REG_SP, 8'h20);
        pulse(6);
        idle(4);
        rd(ISC_REG_STATUS, 8'h05);
        @(posedge clk);
        pin <= 8'h01;
        wake_chk(3000);
        rd(ISC_REG_STATUS, 8'h01);
        test_done();
    end
endmodule : tb_top
